// ==== logic/pvor_regs.sv ====
// Purpose: Holds three PMBus configuration commands with range checks and fault reaction
// Assumes: Write/read strobes are one-cycle pulses from the PMBus layer, synchronous to clk_in
// Notes: Nonvolatile storage itself is outside; this block presents the words to store
//
// Summary of operation
// - Turn-off threshold kept in 0.25 V steps
// - Out-of-range threshold sets CML, invalid-data, alert
// - Rejected threshold write keeps old value
// - Threshold codes 16 to 30, default 16
// - Reject threshold not below turn-on value
// - Threshold exponent fixed at minus two
// - Threshold word: 5-bit exponent, 11-bit mantissa
// - Store-all copies commands to nonvolatile memory
// - Offset applied to current report only
// - Offset 62.5 mA steps, default zero
// - Offset exponent fixed; writes alias into range
// - Sign and six low bits writable
// - OV fault sets OV, output-fault flags, alert
// - Loop slave: OV response NACKed, invalid command
// - Default OV response: restart after 7 rises
// - Ignore bit 0 runs on, 1 shuts down
// - Retry setting only 000 or 111
// - Delay mirrors bit 5; retry or latch off
`timescale 1ns/1ps
module pvor_regs #(
  parameter int CUR_WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] cmd_in,
  input wire logic [15:0] wdata_in,
  input wire logic [10:0] turnon_mant_in,
  input wire logic loop_slave_in,
  input wire logic store_all_in,
  input wire logic ov_detect_in,
  input wire logic fault_clear_in,
  input wire logic rise_done_in,
  input wire logic signed [CUR_WIDTH-1:0] iout_raw_in,
  output logic [15:0] rdata_out,
  output logic nack_out,
  output logic cml_flag_out,
  output logic invalid_data_flag_out,
  output logic invalid_command_flag_out,
  output logic overvoltage_fault_flag_out,
  output logic output_fault_warn_flag_out,
  output logic smbalert_out,
  output logic nvm_write_out,
  output logic [15:0] nvm_turnoff_out,
  output logic [15:0] nvm_offset_out,
  output logic [7:0] nvm_ov_resp_out,
  output logic signed [CUR_WIDTH-1:0] iout_cal_out,
  output logic power_enable_out,
  output logic soft_start_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode and checks
  logic [10:0] turnoff_mant;
  logic sign_bit;
  logic [5:0] low_bits;
  logic ignore_sel;
  logic retry_bit;
  logic sel_voff;
  logic sel_ocal;
  logic sel_ovr;
  logic voff_bad;
  logic ovr_bad;
  logic ovr_refused;
  logic [15:0] voff_word;
  logic [15:0] ocal_word;
  logic [7:0] ovr_byte;
  logic [2:0] wr_retry;

  assign sel_voff = cmd_in == pvor_pkg::CMD_INPUT_TURNOFF_THRESHOLD;
  assign sel_ocal = cmd_in == pvor_pkg::CMD_CURRENT_CALIBRATION_OFFSET;
  assign sel_ovr = cmd_in == pvor_pkg::CMD_OVERVOLTAGE_FAULT_RESPONSE;
  assign wr_retry = wdata_in[pvor_pkg::OVR_RETRY_MSB:pvor_pkg::OVR_RETRY_LSB];

  // Range and ordering checks; exponent bits of the written word are ignored
  always_comb
  begin
    voff_bad = (wdata_in[10:0] < pvor_pkg::VOFF_MANT_MIN) ||
               (wdata_in[10:0] > pvor_pkg::VOFF_MANT_MAX) ||
               (turnon_mant_in <= wdata_in[10:0]);
    ovr_bad = (wr_retry != pvor_pkg::OVR_RETRY_NONE) &&
              (wr_retry != pvor_pkg::OVR_RETRY_ALWAYS);
  end

  assign ovr_refused = sel_ovr && loop_slave_in && (wr_in || rd_in);
  assign nack_out = ovr_refused;

  // Assembled words: fixed exponents and sign extension are wired, not stored
  assign voff_word = {pvor_pkg::VOFF_EXPONENT, turnoff_mant};
  assign ocal_word = {pvor_pkg::OCAL_EXPONENT, sign_bit, {4{sign_bit}}, low_bits};
  assign ovr_byte = {ignore_sel, 1'b0, {3{retry_bit}}, {3{retry_bit}}};

  ////////////////////////////////////////////////////////////////////////////
  // Input turn-off threshold; codes are already whole 0.25 V steps
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      turnoff_mant <= pvor_pkg::VOFF_MANT_DEFAULT;
    else if (wr_in && sel_voff && !voff_bad)
      turnoff_mant <= wdata_in[10:0];
  end

  // Current calibration offset; bits outside the writable ones alias away
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sign_bit <= pvor_pkg::OCAL_DEFAULT[6];
      low_bits <= pvor_pkg::OCAL_DEFAULT[5:0];
    end
    else if (wr_in && sel_ocal)
    begin
      sign_bit <= wdata_in[pvor_pkg::OCAL_SIGN_BIT];
      low_bits <= wdata_in[pvor_pkg::OCAL_LOW_BITS-1:0];
    end
  end

  // Overvoltage response; bit 7 and, of the retry bits, only bit 5 are kept since all retry bits must agree
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ignore_sel <= pvor_pkg::OVR_IGNORE_DEFAULT;
      retry_bit <= pvor_pkg::OVR_RETRY_DEFAULT;
    end
    else if (wr_in && sel_ovr && !loop_slave_in && !ovr_bad)
    begin
      ignore_sel <= wdata_in[pvor_pkg::OVR_IGNORE_BIT];
      retry_bit <= wdata_in[pvor_pkg::OVR_RETRY_MSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
    begin
      if (sel_voff)
        rdata_out <= voff_word;
      else if (sel_ocal)
        rdata_out <= ocal_word;
      else if (sel_ovr && !loop_slave_in)
        rdata_out <= {8'h00, ovr_byte};
      else
        rdata_out <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cml_flag_out <= 1'b0;
      invalid_data_flag_out <= 1'b0;
      invalid_command_flag_out <= 1'b0;
      overvoltage_fault_flag_out <= 1'b0;
      output_fault_warn_flag_out <= 1'b0;
    end
    else
    begin
      if ((wr_in && sel_voff && voff_bad) ||
          (wr_in && sel_ovr && !loop_slave_in && ovr_bad))
      begin
        cml_flag_out <= 1'b1;
        invalid_data_flag_out <= 1'b1;
      end
      else if (fault_clear_in)
      begin
        cml_flag_out <= 1'b0;
        invalid_data_flag_out <= 1'b0;
      end
      if (ovr_refused)
        invalid_command_flag_out <= 1'b1;
      else if (fault_clear_in)
        invalid_command_flag_out <= 1'b0;
      if (ov_detect_in)
      begin
        overvoltage_fault_flag_out <= 1'b1;
        output_fault_warn_flag_out <= 1'b1;
      end
      else if (fault_clear_in)
      begin
        overvoltage_fault_flag_out <= 1'b0;
        output_fault_warn_flag_out <= 1'b0;
      end
    end
  end

  // Alert is the OR of the CML, invalid-command and overvoltage flags, so it stays up while any of those remain
  assign smbalert_out = cml_flag_out | invalid_command_flag_out |
                        overvoltage_fault_flag_out;

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile snapshot
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      nvm_write_out <= 1'b0;
      nvm_turnoff_out <= 16'h0000;
      nvm_offset_out <= 16'h0000;
      nvm_ov_resp_out <= 8'h00;
    end
    else
    begin
      nvm_write_out <= store_all_in;
      if (store_all_in)
      begin
        nvm_turnoff_out <= voff_word;
        nvm_offset_out <= ocal_word;
        nvm_ov_resp_out <= ovr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibrated current: offset is signed in 1/16 A, added unscaled to the raw sample
  logic signed [CUR_WIDTH-1:0] offset_ext;
  assign offset_ext = CUR_WIDTH'($signed({sign_bit, low_bits}));

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      iout_cal_out <= '0;
    else
      iout_cal_out <= CUR_WIDTH'(iout_raw_in + offset_ext);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overvoltage reaction sequencer
  typedef enum logic [1:0] {PVOR_RUN, PVOR_WAIT, PVOR_LATCHED, PVOR_START} pvor_state_t;
  pvor_state_t state;
  logic [2:0] rise_cnt;

  // Retry waits seven rise-time ticks; latch-off holds until the fault clear
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= PVOR_RUN;
      rise_cnt <= 3'h0;
    end
    else
    begin
      case (state)
        PVOR_RUN:
        begin
          rise_cnt <= 3'h0;
          if (ov_detect_in && ignore_sel)
            state <= retry_bit ? PVOR_WAIT : PVOR_LATCHED;
        end
        PVOR_WAIT:
        begin
          if (rise_done_in)
          begin
            if (rise_cnt == pvor_pkg::OVR_RISE_CNT_LAST)
              state <= PVOR_START;
            else
              rise_cnt <= rise_cnt + 3'h1;
          end
        end
        PVOR_LATCHED:
        begin
          if (fault_clear_in)
            state <= PVOR_START;
        end
        PVOR_START:
          state <= PVOR_RUN;
        default:
          state <= PVOR_RUN;
      endcase
    end
  end

  assign power_enable_out = (state == PVOR_RUN) || (state == PVOR_START);
  assign soft_start_out = state == PVOR_START;
endmodule

// ==== pkg/pvor_pkg.sv ====
// Purpose: Constants for the input turn-off threshold, current offset and OV response commands
// Assumes: Command codes arrive already decoded from the PMBus transaction layer
// Notes: Field positions, defaults and limits of the three command words
package pvor_pkg;
  // Command codes
  localparam logic [7:0] CMD_INPUT_TURNOFF_THRESHOLD = 8'h36;
  localparam logic [7:0] CMD_CURRENT_CALIBRATION_OFFSET = 8'h39;
  localparam logic [7:0] CMD_OVERVOLTAGE_FAULT_RESPONSE = 8'h41;
  // Input turn-off threshold word
  localparam logic [4:0] VOFF_EXPONENT = 5'h1e;
  localparam logic [10:0] VOFF_MANT_MIN = 11'h010;
  localparam logic [10:0] VOFF_MANT_MAX = 11'h01e;
  localparam logic [10:0] VOFF_MANT_DEFAULT = 11'h010;
  localparam int VOFF_EXP_LSB = 11;
  // Current calibration offset word
  localparam logic [4:0] OCAL_EXPONENT = 5'h1c;
  localparam int OCAL_SIGN_BIT = 10;
  localparam int OCAL_LOW_BITS = 6;
  localparam logic [6:0] OCAL_DEFAULT = 7'h00;
  // Overvoltage response byte
  localparam int OVR_IGNORE_BIT = 7;
  localparam int OVR_RETRY_MSB = 5;
  localparam int OVR_RETRY_LSB = 3;
  localparam logic [2:0] OVR_RETRY_NONE = 3'h0;
  localparam logic [2:0] OVR_RETRY_ALWAYS = 3'h7;
  localparam logic OVR_IGNORE_DEFAULT = 1'b1;
  localparam logic OVR_RETRY_DEFAULT = 1'b1;
  // Restart waits this many turn-on rise times
  localparam int OVR_RESTART_RISE_TIMES = 7;
  localparam logic [2:0] OVR_RISE_CNT_LAST = 3'(OVR_RESTART_RISE_TIMES - 1);
endpackage

// ==== verification/pvor_regs_properties.sv ====
// Purpose: Port-level properties of the command register block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every pvor_regs instance
`timescale 1ns/1ps
module pvor_regs_properties #(
  parameter int CUR_WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] cmd_in,
  input wire logic [15:0] wdata_in,
  input wire logic loop_slave_in,
  input wire logic store_all_in,
  input wire logic ov_detect_in,
  input wire logic fault_clear_in,
  input wire logic nack_out,
  input wire logic cml_flag_out,
  input wire logic invalid_data_flag_out,
  input wire logic invalid_command_flag_out,
  input wire logic overvoltage_fault_flag_out,
  input wire logic output_fault_warn_flag_out,
  input wire logic smbalert_out,
  input wire logic nvm_write_out
);
  ////////////////////////////////////////////////////////////
  // Everything here is one clock domain
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Request shapes that must be refused
  sequence s_slave_hit;
    (wr_in || rd_in) && cmd_in == 8'h41 && loop_slave_in;
  endsequence
  sequence s_bad_voff;
    wr_in && cmd_in == 8'h36 && (wdata_in[10:0] < 11'h010 || wdata_in[10:0] > 11'h01e);
  endsequence
  sequence s_bad_retry;
    wr_in && cmd_in == 8'h41 && !loop_slave_in && wdata_in[5:3] != 3'h0 && wdata_in[5:3] != 3'h7;
  endsequence
  AST_ALERT: assert property (
    smbalert_out == (cml_flag_out || invalid_command_flag_out || overvoltage_fault_flag_out))
    else $error("alert differs from flag OR");
  AST_NACK: assert property (
    nack_out == ((wr_in || rd_in) && cmd_in == 8'h41 && loop_slave_in))
    else $error("nack wrong");
  AST_INVALID_CMD: assert property (s_slave_hit |=> invalid_command_flag_out)
    else $error("invalid command flag missing");
  AST_VOFF: assert property (s_bad_voff |=> cml_flag_out && invalid_data_flag_out)
    else $error("bad threshold not flagged");
  AST_RETRY: assert property (s_bad_retry |=> cml_flag_out && invalid_data_flag_out)
    else $error("bad retry not flagged");
  AST_OV_FLAGS: assert property (
    ov_detect_in |=> overvoltage_fault_flag_out && output_fault_warn_flag_out)
    else $error("fault flags missing");
  AST_NVM: assert property (store_all_in |=> nvm_write_out ##1 !nvm_write_out)
    else $error("store pulse wrong");
  AST_STICKY: assert property (cml_flag_out && !fault_clear_in |=> cml_flag_out)
    else $error("flag dropped");
  AST_CLR: assert property (fault_clear_in && !ov_detect_in |=> !overvoltage_fault_flag_out)
    else $error("flag not cleared");
endmodule
bind pvor_regs pvor_regs_properties #(.CUR_WIDTH(CUR_WIDTH)) u_props (.*);

// ==== verification/pvor_host.sv ====
// Purpose: Host side of the command interface
// Assumes: Tasks are entered right after a rising edge
// Notes: Strobes idle low, command and data go to inverted values when idle
`timescale 1ns/1ps
module pvor_host (
  input wire logic clk_in,
  output logic wr_in,
  output logic rd_in,
  output logic [7:0] cmd_in,
  output logic [15:0] wdata_in
);
  ////////////////////////////////////////////////////////////
  // Idle at time zero
  initial
  begin
    wr_in = 1'b0;
    rd_in = 1'b0;
    cmd_in = 8'h00;
    wdata_in = 16'h0000;
  end
  // One request held over its sampling edge; one idle edge keeps strobes apart
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    wr_in <= w;
    rd_in <= !w;
    cmd_in <= c;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    cmd_in <= ~c;
    wdata_in <= ~d;
    @(posedge clk_in);
  endtask
endmodule

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the command register block
// Assumes: Host model issues requests; bench drives events
// Notes: Model values kept as integers
`timescale 1ns/1ps
module testbench;
  logic clk_in = 0, rstn_in = 0, loop_slave_in = 0, store_all_in = 0;
  logic ov_detect_in = 0, fault_clear_in = 0, rise_done_in = 0;
  logic [10:0] turnon_mant_in = 11'h01f;
  logic signed [15:0] iout_raw_in = 16'sh0000;
  logic wr_in, rd_in, nack_out, cml_flag_out, invalid_data_flag_out;
  logic invalid_command_flag_out, overvoltage_fault_flag_out, output_fault_warn_flag_out;
  logic smbalert_out, nvm_write_out, power_enable_out, soft_start_out;
  logic [7:0] cmd_in, nvm_ov_resp_out;
  logic [15:0] wdata_in, rdata_out, nvm_turnoff_out, nvm_offset_out, d, lfsr = 16'h0011;
  logic signed [15:0] iout_cal_out;
  int failures = 0, n_compared = 0, n_soft = 0, m = 16, tn = 31, off, ign = 1, rt = 1;
  int n_nack = 0, n_nvm = 0, soft0 = 0;
  int codes[6] = '{15, 16, 30, 31, 18, 17};
  logic [7:0] ovc[3] = '{8'hb8, 8'h80, 8'h38};
  ////////////////////////////////////////////////////////////
  pvor_regs u_pvor_regs (.*);
  pvor_host u_pvor_host (.*);
  // Free-running clock
  initial
  begin
    forever #4 clk_in = ~clk_in;
  end
  // One-cycle pulses are counted as they pass, so no check has to hit their cycle
  always @(posedge clk_in)
  begin
    if (soft_start_out === 1'b1) n_soft <= n_soft + 1;
    if (nack_out === 1'b1) n_nack <= n_nack + 1;
    if (nvm_write_out === 1'b1) n_nvm <= n_nvm + 1;
  end
  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] ovx();
    return {8'h00, 1'(ign), 1'b0, {6{1'(rt)}}};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e, input string nm);
    u_pvor_host.xfer(1'b0, c, 16'h0000);
    chk(nm, rdata_out, e);
  endtask
  task automatic clr();
    fault_clear_in <= 1'b1;
    @(posedge clk_in);
    fault_clear_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rd(8'h36, 16'hf010, "voff");
    rd(8'h39, 16'he000, "ocal");
    rd(8'h41, ovx(), "ovr");
    foreach (codes[i])
    begin
      if (i == 4) tn = 18;
      turnon_mant_in <= 11'(tn);
      lfsr = rnd(lfsr);
      u_pvor_host.xfer(1'b1, 8'h36, {lfsr[15:11], 11'(codes[i])});
      off = (codes[i] >= 16 && codes[i] <= 30 && codes[i] < tn);
      if (off == 1) m = codes[i];
      chk("rej", {cml_flag_out, invalid_data_flag_out, smbalert_out}, off == 1 ? 0 : 7);
      rd(8'h36, {5'h1e, 11'(m)}, "voff");
      clr();
    end
    $display("test threshold done");
    repeat (4)
    begin
      lfsr = rnd(lfsr);
      d = lfsr;
      u_pvor_host.xfer(1'b1, 8'h39, d);
      rd(8'h39, {5'h1c, {5{d[10]}}, d[5:0]}, "ocal");
      off = d[10] ? int'(d[5:0]) - 64 : int'(d[5:0]);
      lfsr = rnd(lfsr);
      iout_raw_in <= lfsr;
      repeat (2) @(posedge clk_in);
      chk("ical", $unsigned(iout_cal_out), 16'(int'($signed(lfsr)) + off));
    end
    $display("test offset done");
    for (int r = 0; r < 8; r++)
    begin
      u_pvor_host.xfer(1'b1, 8'h41, {8'h00, r[0], 1'b0, r[2:0], 3'h5});
      chk("rs", cml_flag_out, r != 0 && r != 7);
      if (r == 0 || r == 7) {ign, rt} = {31'h0, r[0], 31'h0, r[2]};
      rd(8'h41, ovx(), "ovr");
      clr();
    end
    foreach (ovc[i])
    begin
      u_pvor_host.xfer(1'b1, 8'h41, {8'h00, ovc[i]});
      {ign, rt} = {31'h0, ovc[i][7], 31'h0, ovc[i][5]};
      soft0 = n_soft;
      ov_detect_in <= 1'b1;
      @(posedge clk_in);
      ov_detect_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk("pwr", power_enable_out, !ovc[i][7]);
      chk("ov_flags", {overvoltage_fault_flag_out, output_fault_warn_flag_out,
          smbalert_out}, 7);
      repeat (7)
      begin
        chk("early", n_soft - soft0, 0);
        chk("wait", power_enable_out, !ovc[i][7]);
        rise_done_in <= 1'b1;
        @(posedge clk_in);
        rise_done_in <= 1'b0;
        @(posedge clk_in);
      end
      repeat (4) @(posedge clk_in);
      chk("restart", n_soft - soft0, ovc[i][7] && ovc[i][5]);
      chk("latch", power_enable_out, !(ovc[i][7] && !ovc[i][5]));
      clr();
      chk("on", power_enable_out, 1'b1);
    end
    $display("test response done");
    loop_slave_in <= 1'b1;
    u_pvor_host.xfer(1'b1, 8'h41, 16'h0080);
    rd(8'h41, 16'h0000, "slave");
    chk("inv_cmd", invalid_command_flag_out, 1'b1);
    loop_slave_in <= 1'b0;
    rd(8'h41, ovx(), "kept");
    chk("nack", n_nack, 2);
    store_all_in <= 1'b1;
    @(posedge clk_in);
    store_all_in <= 1'b0;
    // Extra edge lets the pulse counter settle before it is read
    repeat (2) @(posedge clk_in);
    chk("nvm_wr", n_nvm, 1);
    chk("nvm", nvm_turnoff_out, {5'h1e, 11'(m)});
    chk("nvm_ov", nvm_ov_resp_out, ovx());
    chk("nvm_of", nvm_offset_out, {5'h1c, {5{d[10]}}, d[5:0]});
    $display("test slave and store done");
    finish_test();
  end
endmodule
